// ### fcp_regs.svh
// Register indices, field positions and reset values of the CPU FIFO port.
// Assumes inclusion by the package and design files; byte address is index times four.
`ifndef FCP_REGS_SVH
`define FCP_REGS_SVH

// ----------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------
`define FCP_IDX_ROLE 8'h1f
`define FCP_IDX_RD0 8'h20
`define FCP_IDX_RD1 8'h21
`define FCP_IDX_WR0 8'h22
`define FCP_IDX_WR1 8'h23
`define FCP_IDX_RDCNT 8'h24
`define FCP_IDX_FREE 8'h26
`define FCP_IDX_ATTACH 8'h30

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define FCP_ROLE_BIT 0
`define FCP_VALID_BIT 15
`define FCP_CNT_W 13
`define FCP_ATT_RD_LSB 0
`define FCP_ATT_RD_EN 3
`define FCP_ATT_WR_LSB 4
`define FCP_ATT_WR_EN 7

// ----------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------
`define FCP_ROLE_RST 1'b0
`define FCP_ATT_RST 8'h00
`define FCP_AREAS 3'd6
`define FCP_DEPTH 13'd64
`define FCP_PTR_W 6
`define FCP_MEM_AW 9

`endif

// ### fcp_pkg.sv
// Types shared by the CPU FIFO port and its storage.
// Assumes fcp_regs.svh is on the include path.
`include "fcp_regs.svh"

package fcp_pkg;
    typedef enum logic {FCP_IDLE, FCP_DATA} fcp_phase_t;
    typedef logic [2:0] fcp_area_t;
    typedef logic [`FCP_PTR_W-1:0] fcp_ptr_t;
    typedef logic [`FCP_CNT_W-1:0] fcp_cnt_t;
endpackage

// ### fcp_mem.sv
// Byte storage for the six packet areas, one write and one read port.
// Assumes a single clock; read data is registered and follows the read address each cycle.
`timescale 1ns/1ns
`include "fcp_regs.svh"

module fcp_mem
    import fcp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_wr_en,
    input wire logic [`FCP_MEM_AW-1:0] i_wr_addr,
    input wire logic [7:0] i_wr_data,
    input wire logic [`FCP_MEM_AW-1:0] i_rd_addr,
    output logic [7:0] o_rd_data
);
    logic [7:0] ram [0:(1<<`FCP_MEM_AW)-1];

    always_ff @(posedge i_clock)
    begin
        if (i_wr_en)
        begin
            ram[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clock)
    begin
        o_rd_data <= ram[i_rd_addr];
    end
endmodule

// ### fcp_cpu_port.sv
// CPU FIFO access port with role select, reached as an AHB-Lite slave.
// Assumes one AHB-Lite master, word transfers, and i_sleep from an asynchronous source.
//
// Summary of operation
// - role bit 0 picks device (0) or host (1); bits 7..1 reserved.
// - role 0 clocks common and device blocks, stops the host block clock.
// - role 1 clocks common and host blocks, stops the device block clock.
// - role register stays readable and writable during sleep.
// - read-data registers return bytes from the read-attached area.
// - at a byte boundary only one lane of the read pair carries data.
// - write-data registers push bytes into the write-attached area.
// - at a byte boundary only one lane of the write pair is stored.
// - count bit 15 is 1 only while a read area is attached.
// - count bits 12..0 give readable bytes; bits 14..13 reserved.
// - a separate 13-bit free-space count reports write-area room.
`timescale 1ns/1ns
`include "fcp_regs.svh"

module fcp_cpu_port
    import fcp_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_sleep,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic [31:0] o_hrdata,
    output logic o_hresp,
    output logic o_common_clk_en,
    output logic o_device_clk_en,
    output logic o_host_clk_en
);
    // ------------------------------------------------------------------
    // Sleep input synchroniser
    // ------------------------------------------------------------------
    logic sleep_meta;
    logic sleep_s;

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            sleep_meta <= 1'b0;
            sleep_s <= 1'b0;
        end
        else
        begin
            sleep_meta <= i_sleep;
            sleep_s <= sleep_meta;
        end
    end

    // ------------------------------------------------------------------
    // Bus phase tracking
    // ------------------------------------------------------------------
    fcp_phase_t phase;
    logic [7:0] acc_idx;
    logic acc_write;
    logic acc_map;
    logic addr_ok;
    logic do_access;

    assign addr_ok = i_hsel && i_htrans[1] && i_hready;
    assign do_access = (phase == FCP_DATA);

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            phase <= FCP_IDLE;
        end
        else
        begin
            case (phase)
                FCP_IDLE: phase <= addr_ok ? FCP_DATA : FCP_IDLE;
                FCP_DATA: phase <= FCP_IDLE;
                default: phase <= FCP_IDLE;
            endcase
        end
    end

    // Only whole aligned words inside the low window are mapped.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            acc_idx <= 8'h00;
            acc_write <= 1'b0;
            acc_map <= 1'b0;
        end
        else if (addr_ok)
        begin
            acc_idx <= i_haddr[9:2];
            acc_write <= i_hwrite;
            acc_map <= (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'h0)
                && (i_hsize == 3'h2);
        end
    end

    // Every access takes one wait state so read data leaves a register.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
        else
        begin
            o_hreadyout <= !addr_ok;
            o_hresp <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Role select and clock delivery
    // ------------------------------------------------------------------
    logic role_select_bit;
    logic [7:0] area_attach_config;

    // role in sleep: the role write ignores the sleep state.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            role_select_bit <= `FCP_ROLE_RST;
        end
        // role bit: only bit 0 is stored.
        else if (do_access && acc_write && acc_map && acc_idx == `FCP_IDX_ROLE)
        begin
            role_select_bit <= i_hwdata[`FCP_ROLE_BIT];
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            area_attach_config <= `FCP_ATT_RST;
        end
        else if (do_access && acc_write && acc_map && acc_idx == `FCP_IDX_ATTACH)
        begin
            area_attach_config <= i_hwdata[7:0];
        end
    end

    // Enables are registered so the gating cells see a glitch-free level.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_common_clk_en <= 1'b1;
            o_device_clk_en <= 1'b1;
            o_host_clk_en <= 1'b0;
        end
        else
        begin
            o_common_clk_en <= 1'b1;
            // device clocks: on while the role is device.
            o_device_clk_en <= !role_select_bit;
            // host clocks: on while the role is host.
            o_host_clk_en <= role_select_bit;
        end
    end

    // ------------------------------------------------------------------
    // Area selection and counts
    // ------------------------------------------------------------------
    fcp_area_t rd_area;
    fcp_area_t wr_area;
    logic cpu_read_attach;
    logic cpu_write_attach;
    fcp_ptr_t head [0:`FCP_AREAS-1];
    fcp_ptr_t tail [0:`FCP_AREAS-1];
    fcp_cnt_t area_count [0:`FCP_AREAS-1];
    fcp_cnt_t readable_byte_count;
    fcp_cnt_t wr_count;
    fcp_cnt_t free_space_count;
    logic readable_count_valid;
    logic [7:0] mem_rd_data;

    assign rd_area = area_attach_config[`FCP_ATT_RD_LSB +: 3];
    assign wr_area = area_attach_config[`FCP_ATT_WR_LSB +: 3];
    assign cpu_read_attach = area_attach_config[`FCP_ATT_RD_EN] && (rd_area < `FCP_AREAS);
    assign cpu_write_attach = area_attach_config[`FCP_ATT_WR_EN] && (wr_area < `FCP_AREAS);
    // count validity: valid only with a read area attached.
    assign readable_count_valid = cpu_read_attach;
    // readable bytes: the attached area's fill level.
    assign readable_byte_count = cpu_read_attach ? area_count[rd_area] : 13'h0000;
    assign wr_count = cpu_write_attach ? area_count[wr_area] : 13'h0000;
    // free space: room left in the write-attached area.
    assign free_space_count = cpu_write_attach ? (`FCP_DEPTH - wr_count) : 13'h0000;

    // ------------------------------------------------------------------
    // Pops and pushes
    // ------------------------------------------------------------------
    logic is_rd_lane;
    logic is_wr_lane;
    logic fifo_rd_req;
    logic fifo_wr_req;
    logic do_pop;
    logic do_push;

    assign is_rd_lane = (acc_idx == `FCP_IDX_RD0) || (acc_idx == `FCP_IDX_RD1);
    assign is_wr_lane = (acc_idx == `FCP_IDX_WR0) || (acc_idx == `FCP_IDX_WR1);
    // Data registers are closed while asleep; the role register is not.
    assign fifo_rd_req = do_access && acc_map && !acc_write && is_rd_lane && !sleep_s;
    assign fifo_wr_req = do_access && acc_map && acc_write && is_wr_lane && !sleep_s;
    // read boundary: an access with no byte left carries nothing.
    assign do_pop = fifo_rd_req && (readable_byte_count != 13'h0000);
    // write boundary: a lane with no room left is not stored.
    // full drop: writes past the free space are discarded.
    assign do_push = fifo_wr_req && (free_space_count != 13'h0000);

    // count upkeep: one byte in or out per data access.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            for (int i = 0; i < `FCP_AREAS; i++)
            begin
                head[i] <= '0;
                tail[i] <= '0;
                area_count[i] <= '0;
            end
        end
        else if (do_pop)
        begin
            head[rd_area] <= head[rd_area] + 1'b1;
            area_count[rd_area] <= area_count[rd_area] - 1'b1;
        end
        else if (do_push)
        begin
            tail[wr_area] <= tail[wr_area] + 1'b1;
            area_count[wr_area] <= area_count[wr_area] + 1'b1;
        end
    end

    logic attach_wr;
    logic [2:0] new_rd_area;
    logic [`FCP_MEM_AW-1:0] mem_wr_addr;
    logic [`FCP_MEM_AW-1:0] mem_rd_addr;
    logic fwd_hit;
    logic [7:0] fwd_data;
    logic [7:0] rd_byte;

    // The read port is addressed with next-cycle values, so a back-to-back read
    // after a pop or an attach change does not see a stale byte.
    assign attach_wr = do_access && acc_write && acc_map && acc_idx == `FCP_IDX_ATTACH;
    assign new_rd_area = i_hwdata[`FCP_ATT_RD_LSB +: 3];
    assign mem_wr_addr = {wr_area, tail[wr_area]};
    assign mem_rd_addr = attach_wr ? {new_rd_area, head[new_rd_area]}
        : {rd_area, head[rd_area] + fcp_ptr_t'(do_pop)};

    // A byte pushed into the slot being read is forwarded for one cycle,
    // because the memory register still holds the old contents then.
    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            fwd_hit <= 1'b0;
            fwd_data <= 8'h00;
        end
        else
        begin
            fwd_hit <= do_push && (mem_wr_addr == mem_rd_addr);
            fwd_data <= i_hwdata[7:0];
        end
    end

    assign rd_byte = fwd_hit ? fwd_data : mem_rd_data;

    // attached write: bytes land in the write area's slot.
    fcp_mem u_mem (
        .i_clock(i_clock),
        .i_wr_en(do_push),
        .i_wr_addr(mem_wr_addr),
        .i_wr_data(i_hwdata[7:0]),
        .i_rd_addr(mem_rd_addr),
        .o_rd_data(mem_rd_data)
    );

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] next_rdata;

    // reserved zero: unused bits and unmapped words read 0.
    always_comb
    begin
        next_rdata = 32'h00000000;
        if (acc_map && !acc_write)
        begin
            case (acc_idx)
                `FCP_IDX_ROLE: next_rdata = {31'h00000000, role_select_bit};
                // attached read: byte from the read area's head.
                `FCP_IDX_RD0, `FCP_IDX_RD1:
                    next_rdata = do_pop ? {24'h000000, rd_byte} : 32'h00000000;
                // coherent count: both halves leave in one word.
                `FCP_IDX_RDCNT:
                    next_rdata = {16'h0000, readable_count_valid, 2'b00, readable_byte_count};
                `FCP_IDX_FREE: next_rdata = {19'h00000, free_space_count};
                `FCP_IDX_ATTACH: next_rdata = {24'h000000, area_attach_config};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge i_clock)
    begin
        if (i_sys_rst)
        begin
            o_hrdata <= 32'h00000000;
        end
        else if (do_access)
        begin
            o_hrdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);

    sequence bus_addr_s;
        addr_ok && phase == FCP_IDLE;
    endsequence

    sequence bus_wait_s;
        !o_hreadyout ##1 o_hreadyout;
    endsequence

    bus_wait_state_a: assert property (bus_addr_s |=> bus_wait_s)
        else $error("access did not finish after one wait state");
    device_clock_a: assert property (!role_select_bit |=>
        o_device_clk_en && !o_host_clk_en && o_common_clk_en)
        else $error("device role clock enables wrong");
    host_clock_a: assert property (role_select_bit |=>
        !o_device_clk_en && o_host_clk_en && o_common_clk_en)
        else $error("host role clock enables wrong");
    role_sleep_write_a: assert property (sleep_s && do_access && acc_write && acc_map
        && acc_idx == `FCP_IDX_ROLE |=> role_select_bit == $past(i_hwdata[0]))
        else $error("role write lost during sleep");
    pop_data_a: assert property (do_pop |=>
        o_hrdata == {24'h000000, $past(rd_byte)})
        else $error("read lane data not from attached area");
    empty_lane_a: assert property (fifo_rd_req && readable_byte_count == 13'h0000 |=>
        o_hrdata == 32'h00000000 && $stable(readable_byte_count))
        else $error("empty read lane returned data");
    pop_count_a: assert property (do_pop |=>
        readable_byte_count == $past(readable_byte_count) - 13'h0001)
        else $error("readable count not reduced by a pop");
    push_count_a: assert property (do_push |=> wr_count == $past(wr_count) + 13'h0001)
        else $error("write area count not raised by a push");
    full_drop_a: assert property (fifo_wr_req && free_space_count == 13'h0000 |=>
        $stable(wr_count))
        else $error("write stored with no free space");
    count_read_a: assert property (do_access && acc_map && !acc_write
        && acc_idx == `FCP_IDX_RDCNT |=> o_hrdata[15] == $past(cpu_read_attach)
        && o_hrdata[14:13] == 2'b00
        && o_hrdata[12:0] == $past(readable_byte_count))
        else $error("readable count word wrong");
    count_reserved_a: assert property (do_access && acc_map && !acc_write
        && acc_idx == `FCP_IDX_RDCNT |=> o_hrdata[31:16] == 16'h0000)
        else $error("readable count upper bits not zero");
    free_read_a: assert property (do_access && acc_map && !acc_write
        && acc_idx == `FCP_IDX_FREE |=> o_hrdata[12:0] == $past(free_space_count)
        && o_hrdata[31:13] == 19'h00000)
        else $error("free space word wrong");
    role_reserved_a: assert property (do_access && acc_map && !acc_write
        && acc_idx == `FCP_IDX_ROLE |=> o_hrdata[31:1] == 31'h00000000)
        else $error("role reserved bits not zero");
endmodule

// ### fcp_host_model.sv
// Host processor model that reaches the CPU FIFO port as the single AHB-Lite master.
// Assumes one slave whose hreadyout is the bus hready, and word transfers only.
`timescale 1ns/1ns

module fcp_host_model
(
    input wire logic i_clock,
    input wire logic i_hreadyout,
    input wire logic [31:0] i_hrdata,
    output logic o_hsel,
    output logic [31:0] o_haddr,
    output logic [1:0] o_htrans,
    output logic o_hwrite,
    output logic [2:0] o_hsize,
    output logic [31:0] o_hwdata
);
    initial
    begin
        o_hsel = 1'b0;
        o_haddr = 32'h0;
        o_htrans = 2'b00;
        o_hwrite = 1'b0;
        o_hsize = 3'b010;
        o_hwdata = 32'h0;
    end

    // ------------------------------------------------------------------
    // Single transfer
    // ------------------------------------------------------------------
    // The wait is bounded so a stuck slave is reported, not hung on.
    task automatic access(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                          output logic [31:0] rd, output logic ok);
        int n;
        begin
            n = 0;
            @(posedge i_clock);
            o_hsel <= 1'b1;
            o_htrans <= 2'b10;
            o_haddr <= addr;
            o_hwrite <= wr;
            o_hsize <= 3'b010;
            do
            begin
                @(posedge i_clock);
                n++;
            end
            while (i_hreadyout !== 1'b1 && n < 64);
            o_htrans <= 2'b00;
            o_hwdata <= wd;
            do
            begin
                @(posedge i_clock);
                n++;
            end
            while (i_hreadyout !== 1'b1 && n < 64);
            rd = i_hrdata;
            ok = (n < 64);
            // A released data bus shows the inverse, never a stale value.
            o_hwdata <= ~wd;
            o_hsel <= 1'b0;
        end
    endtask
endmodule

// ### tb.sv
// Self-checking bench for the CPU FIFO port with role select.
// Assumes fcp_regs.svh on the include path and the host model as bus master.
`timescale 1ns/1ns
`include "fcp_regs.svh"

module tb;
    localparam logic [31:0] A_ROLE = {22'h0, `FCP_IDX_ROLE, 2'b00};
    localparam logic [31:0] A_RD0 = {22'h0, `FCP_IDX_RD0, 2'b00};
    localparam logic [31:0] A_RD1 = {22'h0, `FCP_IDX_RD1, 2'b00};
    localparam logic [31:0] A_WR0 = {22'h0, `FCP_IDX_WR0, 2'b00};
    localparam logic [31:0] A_WR1 = {22'h0, `FCP_IDX_WR1, 2'b00};
    localparam logic [31:0] A_CNT = {22'h0, `FCP_IDX_RDCNT, 2'b00};
    localparam logic [31:0] A_FREE = {22'h0, `FCP_IDX_FREE, 2'b00};
    localparam logic [31:0] A_ATT = {22'h0, `FCP_IDX_ATTACH, 2'b00};
    localparam logic [31:0] A_BAD = 32'h0000_00fc;

    logic clock = 1'b0;
    logic i_sys_rst;
    logic i_sleep;
    logic hsel, hwrite, hreadyout, hresp, common_en, device_en, host_en;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int bad_count;
    int check_count;
    int i;

    always
    begin
        #4 clock = ~clock;
    end

    fcp_cpu_port u_fcp_cpu_port (.i_clock(clock), .i_sys_rst(i_sys_rst), .i_sleep(i_sleep),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
        .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout), .o_hreadyout(hreadyout),
        .o_hrdata(hrdata), .o_hresp(hresp), .o_common_clk_en(common_en),
        .o_device_clk_en(device_en), .o_host_clk_en(host_en));

    fcp_host_model u_fcp_host_model (.i_clock(clock), .i_hreadyout(hreadyout),
        .i_hrdata(hrdata), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
                        output logic [31:0] rd);
        logic ok;
        u_fcp_host_model.access(wr, addr, wd, rd, ok);
        if (!ok)
        begin
            bad_count++;
            $display("Error bus wait expected ready seen timeout");
            report_and_stop();
        end
        else
            chk("response", 32'h0, {31'h0, hresp});
    endtask

    task automatic wr(input logic [31:0] addr, input logic [31:0] wd);
        logic [31:0] d;
        xfer(1'b1, addr, wd, d);
    endtask

    task automatic rd(input string name, input logic [31:0] addr, input logic [31:0] exp);
        logic [31:0] d;
        xfer(1'b0, addr, 32'h0, d);
        chk(name, exp, d);
    endtask

    // Enables lag the role bit by one cycle, so two edges are allowed first.
    task automatic ens(input logic [2:0] exp);
        repeat (2) @(posedge clock);
        chk("clock enables", {29'h0, exp}, {29'h0, common_en, device_en, host_en});
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial
    begin
        i_sys_rst = 1'b1;
        i_sleep = 1'b0;
        bad_count = 0;
        check_count = 0;
        repeat (5) @(posedge clock);
        i_sys_rst <= 1'b0;
        ens(3'b110);
        rd("role", A_ROLE, 32'h0);
        rd("count", A_CNT, 32'h0);
        wr(A_ROLE, 32'hffff_ffff);
        rd("role", A_ROLE, 32'h1);
        ens(3'b101);
        wr(A_ROLE, 32'h0000_00fe);
        rd("role", A_ROLE, 32'h0);
        ens(3'b110);
        wr(A_ATT, 32'h88);
        rd("count", A_CNT, 32'h8000);
        rd("free", A_FREE, 32'd64);
        for (i = 0; i < 63; i++)
            wr(i[0] ? A_WR1 : A_WR0, {24'hffffff, 8'(i + 1)});
        rd("free", A_FREE, 32'd1);
        rd("count", A_CNT, 32'h0000_803f);
        wr(A_WR0, 32'h40);
        wr(A_WR1, 32'hee);
        rd("count", A_CNT, 32'h0000_8040);
        rd("free", A_FREE, 32'h0);
        for (i = 0; i < 64; i++)
            rd("data", i[0] ? A_RD1 : A_RD0, 32'(i + 1));
        rd("count", A_CNT, 32'h8000);
        rd("empty", A_RD0, 32'h0);
        wr(A_WR0, 32'h5a);
        rd("lane0", A_RD0, 32'h5a);
        rd("lane1", A_RD1, 32'h0);
        wr(A_ATT, 32'h99);
        wr(A_WR1, 32'h3c);
        wr(A_ATT, 32'h98);
        rd("count", A_CNT, 32'h8000);
        wr(A_ATT, 32'h99);
        rd("count", A_CNT, 32'h8001);
        rd("data", A_RD0, 32'h3c);
        wr(A_ATT, 32'hee);
        rd("count", A_CNT, 32'h0);
        wr(A_ATT, 32'h88);
        i_sleep <= 1'b1;
        repeat (4) @(posedge clock);
        wr(A_ROLE, 32'h1);
        rd("role", A_ROLE, 32'h1);
        ens(3'b101);
        wr(A_WR0, 32'h77);
        rd("count", A_CNT, 32'h8000);
        i_sleep <= 1'b0;
        repeat (4) @(posedge clock);
        wr(A_ROLE, 32'h0);
        wr(A_BAD, 32'hffff_ffff);
        rd("unmapped", A_BAD, 32'h0);
        rd("write only", A_WR0, 32'h0);
        report_and_stop();
    end
endmodule
